//--- isa_switch_pkg.sv
`default_nettype none
package isa_switch_pkg;
   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam int         ADDR_W      = 8;
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_STATUS  = 8'h04;
   localparam logic [7:0] OFF_CS_BASE = 8'h08;
   localparam logic [7:0] OFF_EIP     = 8'h0c;
   localparam logic [7:0] OFF_OPCODE  = 8'h10;
   localparam logic [7:0] OFF_OPERAND = 8'h14;
   localparam logic [7:0] OFF_ISSUE   = 8'h18;
   localparam logic [7:0] OFF_TARGET  = 8'h1c;
   localparam logic [7:0] OFF_LINK    = 8'h20;
   localparam logic [7:0] OFF_RESULT  = 8'h24;
   localparam logic [7:0] OFF_RSE     = 8'h28;

   // -----------------------------------------------------------------
   // Control bits
   // -----------------------------------------------------------------
   localparam int CTRL_ENTER      = 0;
   localparam int CTRL_EAGER      = 1;
   localparam int CTRL_NAT_ABORT  = 2;
   localparam int CTRL_FP_FAULT   = 3;
   localparam int CTRL_SIGNALLING_NAN_VALUE_ENTRY = 4;
   localparam int CTRL_OP32       = 5;
   localparam int CTRL_SET_RF     = 6;
   localparam int CTRL_INTR       = 7;
   localparam int CTRL_ADVANCED_LOAD_TABLE_FILL  = 8;
   localparam logic [31:0] CTRL_STORE_MASK = 32'h0000_003e;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0020;

   // -----------------------------------------------------------------
   // Status bits
   // -----------------------------------------------------------------
   localparam int ST_LEGACY     = 0;
   localparam int ST_RSE_ACT    = 1;
   localparam int ST_ADVANCED_LOAD_TABLE_VALID = 2;
   localparam int ST_RF         = 3;
   localparam int ST_NAT_ABORT  = 4;
   localparam int ST_FP_FAULT   = 5;
   localparam int ST_WAIT_FAULT = 6;
   localparam int ST_JUMPED     = 7;
   localparam int ST_BAD_OP     = 8;
   localparam int ST_RES_TOKEN  = 9;
   localparam int ST_RES_SIGNALLING_NAN_VALUE   = 10;
   localparam int ST_STACK_VAL  = 11;
   localparam int ST_FP_CONV    = 12;
   localparam logic [31:0] STICKY_MASK = 32'h0000_01f0;

   // -----------------------------------------------------------------
   // Instruction encoding and values
   // -----------------------------------------------------------------
   localparam logic [7:0]  OPC_ESC     = 8'h0f;
   localparam logic [7:0]  OPC_IND     = 8'h00;
   localparam logic [7:0]  OPC_ABS     = 8'hb8;
   localparam logic [2:0]  MODRM_JUMP  = 3'h6;
   localparam logic [31:0] ALIGN_MASK  = 32'hffff_fff0;
   localparam logic [31:0] SIGNALLING_NAN_VALUE_VALUE  = 32'h7fa0_0000;
   localparam logic [31:0] LOW16_MASK  = 32'h0000_ffff;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {CLS_JUMP, CLS_INT, CLS_FP, CLS_VEC} op_class_t;

   typedef struct packed {
      logic [26:0] unused;
      logic        pend_fp_exc;
      logic        fp_token;
      logic        int_token;
      op_class_t   cls;
   } issue_t;

   typedef struct packed {
      logic [7:0] unused_hi;
      logic [3:0] len;
      logic       unused_b;
      logic [2:0] modrm_reg;
      logic [7:0] op2;
      logic [7:0] esc;
   } opcode_t;
endpackage
`default_nettype wire

//--- legacy_to_native_isa_switch.sv
// What this block does
// - Entering legacy mode clears the advanced load table valid state.
// - Legacy integer op on token register propagates token or aborts.
// - An integer op never uses a token-flagged input silently.
// - An abort may leave some state updated mid-instruction.
// - Float token registers may become signalling NaN at entry or use.
// - Legacy float op on float token propagates it or faults.
// - Packed-vector ops ignore the float token, mantissa used as data.
// - Multimedia ops likewise ignore the token and use the mantissa.
// - Decode indirect and absolute forms of jump-to-native.
// - Jump-to-native switches to native set, fetch at the target.
// - Absolute target is displacement plus code base, 16-byte aligned.
// - Indirect target is operand value plus code base.
// - Jump writes next sequential legacy address into link register.
// - Jump first waits on float, pending exception faults the jump.
// - Jump is neither a memory fence nor a serialising step.
// - Successful jump clears the resume flag.
// - Eager register stack engine may load once native execution starts.
// - Leaving legacy marks stacked registers invalid, clean count zero.
// - Register stack engine stays inactive while in legacy mode.
`timescale 1ns/1ps
`default_nettype none
module legacy_to_native_isa_switch
   import isa_switch_pkg::*;
#(
   parameter int CLEAN_W   = 8,
   parameter int CLEAN_MAX = 96
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Write address channel
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              awvalid,
   output var  logic              awready,
   // Write data channel
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output var  logic              wready,
   // Write response channel
   output var  logic [1:0]        bresp,
   output var  logic              bvalid,
   input  wire logic              bready,
   // Read address channel
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic [2:0]        arprot,
   input  wire logic              arvalid,
   output var  logic              arready,
   // Read data channel
   output var  logic [31:0]       rdata,
   output var  logic [1:0]        rresp,
   output var  logic              rvalid,
   input  wire logic              rready
);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Legacy 16-bit size drops the upper half of an operand or pointer.
   function automatic logic [31:0] size_fit(input logic [31:0] v,
                                            input logic        op32);
      return op32 ? v : (v & LOW16_MASK);
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_CS_BASE) ||
             (a == OFF_EIP) || (a == OFF_OPCODE) || (a == OFF_OPERAND) ||
             (a == OFF_ISSUE) || (a == OFF_TARGET) || (a == OFF_LINK) ||
             (a == OFF_RESULT) || (a == OFF_RSE);
   endfunction

   // ------------------------------------------------------------------
   // Bus state
   // ------------------------------------------------------------------
   logic              aw_held_reg;
   logic              w_held_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0]       wdata_reg;
   logic [3:0]        wstrb_reg;
   logic              awready_reg;
   logic              wready_reg;
   logic              bvalid_reg;
   logic [1:0]        bresp_reg;
   logic              arready_reg;
   logic              rvalid_reg;
   logic [31:0]       rdata_reg;
   logic [1:0]        rresp_reg;

   // ------------------------------------------------------------------
   // Block state
   // ------------------------------------------------------------------
   logic [31:0]        ctrl_reg;
   logic [31:0]        status_reg;
   logic [31:0]        cs_base_reg;
   logic [31:0]        eip_reg;
   logic [31:0]        opcode_reg;
   logic [31:0]        operand_reg;
   logic [31:0]        target_reg;
   logic [31:0]        link_reg;
   logic [31:0]        result_reg;
   logic [CLEAN_W-1:0] clean_reg;
   logic [31:0]        status_next;
   logic [31:0]        eip_next;
   logic [31:0]        target_next;
   logic [31:0]        link_next;
   logic [31:0]        result_next;
   logic [CLEAN_W-1:0] clean_next;

   // ------------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------------
   wire do_write   = aw_held_reg && w_held_reg && !bvalid_reg;
   wire wr_ok      = do_write && mapped(awaddr_reg);
   wire wr_ctrl    = wr_ok && (awaddr_reg == OFF_CTRL);
   wire wr_status  = wr_ok && (awaddr_reg == OFF_STATUS);
   wire wr_cs_base = wr_ok && (awaddr_reg == OFF_CS_BASE);
   wire wr_eip     = wr_ok && (awaddr_reg == OFF_EIP);
   wire wr_opcode  = wr_ok && (awaddr_reg == OFF_OPCODE);
   wire wr_operand = wr_ok && (awaddr_reg == OFF_OPERAND);
   wire wr_issue   = wr_ok && (awaddr_reg == OFF_ISSUE);
   wire [31:0] wr_word = merge(32'h0000_0000, wdata_reg, wstrb_reg);

   wire in_legacy  = status_reg[ST_LEGACY];
   wire op32       = ctrl_reg[CTRL_OP32];
   wire enter      = wr_ctrl && wr_word[CTRL_ENTER] && !in_legacy;
   wire intr_exit  = wr_ctrl && wr_word[CTRL_INTR] && in_legacy;
   wire set_rf     = wr_ctrl && wr_word[CTRL_SET_RF];
   wire advanced_load_table_fill  = wr_ctrl && wr_word[CTRL_ADVANCED_LOAD_TABLE_FILL] && !in_legacy;
   wire [31:0] sticky_clr = wr_status ? (wr_word & STICKY_MASK)
                                      : 32'h0000_0000;

   // ------------------------------------------------------------------
   // Instruction decode
   // ------------------------------------------------------------------
   wire issue_t  iss  = issue_t'(wdata_reg);
   wire opcode_t opc  = opcode_t'(opcode_reg);
   wire is_esc   = (opc.esc == OPC_ESC);
   wire is_ind   = is_esc && (opc.op2 == OPC_IND) &&
                   (opc.modrm_reg == MODRM_JUMP);
   wire is_abs   = is_esc && (opc.op2 == OPC_ABS);
   wire [31:0] opnd     = size_fit(operand_reg, op32);
   wire [31:0] ind_tgt  = opnd + cs_base_reg;
   wire [31:0] abs_tgt  = (opnd + cs_base_reg) & ALIGN_MASK;
   wire [31:0] seq_eip  = size_fit(eip_reg + {28'h0000000, opc.len}, op32);
   wire run     = wr_issue && in_legacy;
   wire jump_op = run && (iss.cls == CLS_JUMP);
   wire jump_ok = jump_op && (is_ind || is_abs) && !iss.pend_fp_exc;
   wire wait_ft = jump_op && (is_ind || is_abs) && iss.pend_fp_exc;
   wire int_op  = run && (iss.cls == CLS_INT);
   wire fp_op   = run && (iss.cls == CLS_FP);
   wire vec_op  = run && (iss.cls == CLS_VEC);
   wire nat_ab  = int_op && iss.int_token && ctrl_reg[CTRL_NAT_ABORT];
   wire fp_conv = status_reg[ST_FP_CONV];
   wire fp_ft   = fp_op && iss.fp_token && !fp_conv &&
                  ctrl_reg[CTRL_FP_FAULT];
   wire bad_op  = (wr_issue && !in_legacy) ||
                  (jump_op && !is_ind && !is_abs);
   wire leave   = jump_ok || intr_exit;
   wire rse_on  = !in_legacy && !enter && ctrl_reg[CTRL_EAGER];

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      status_next = status_reg & ~sticky_clr;
      eip_next    = wr_eip ? merge(eip_reg, wdata_reg, wstrb_reg) : eip_reg;
      target_next = target_reg;
      link_next   = link_reg;
      result_next = result_reg;
      clean_next  = clean_reg;
      if (set_rf) begin
         status_next[ST_RF] = 1'b1;
      end
      if (advanced_load_table_fill) begin
         status_next[ST_ADVANCED_LOAD_TABLE_VALID] = 1'b1;
      end
      if (enter) begin
         status_next[ST_LEGACY]     = 1'b1;
         status_next[ST_ADVANCED_LOAD_TABLE_VALID] = 1'b0;
         status_next[ST_FP_CONV]    = ctrl_reg[CTRL_SIGNALLING_NAN_VALUE_ENTRY];
      end
      if (wait_ft) begin
         status_next[ST_WAIT_FAULT] = 1'b1;
      end
      if (jump_ok) begin
         target_next = is_abs ? abs_tgt : ind_tgt;
         link_next   = seq_eip;
         eip_next    = is_abs ? abs_tgt : ind_tgt;
         status_next[ST_RF]     = 1'b0;
         status_next[ST_JUMPED] = 1'b1;
      end
      if (leave) begin
         status_next[ST_LEGACY]    = 1'b0;
         status_next[ST_STACK_VAL] = 1'b0;
         status_next[ST_FP_CONV]   = 1'b0;
         clean_next = '0;
      end else if (rse_on && (clean_reg < CLEAN_W'(CLEAN_MAX))) begin
         clean_next = clean_reg + CLEAN_W'(1);
         status_next[ST_STACK_VAL] = 1'b1;
      end
      // An abort stops the op with eip already moved past it.
      if (int_op) begin
         eip_next = seq_eip;
         if (nat_ab) begin
            status_next[ST_NAT_ABORT] = 1'b1;
         end else begin
            result_next = operand_reg;
            status_next[ST_RES_TOKEN] = iss.int_token;
            status_next[ST_RES_SIGNALLING_NAN_VALUE]  = 1'b0;
         end
      end
      if (fp_op) begin
         eip_next = seq_eip;
         if (fp_ft) begin
            status_next[ST_FP_FAULT] = 1'b1;
         end else if (iss.fp_token) begin
            result_next = SIGNALLING_NAN_VALUE_VALUE;
            status_next[ST_RES_TOKEN] = !fp_conv;
            status_next[ST_RES_SIGNALLING_NAN_VALUE]  = 1'b1;
         end else begin
            result_next = operand_reg;
            status_next[ST_RES_TOKEN] = 1'b0;
            status_next[ST_RES_SIGNALLING_NAN_VALUE]  = 1'b0;
         end
      end
      if (vec_op) begin
         eip_next    = seq_eip;
         result_next = operand_reg;
         status_next[ST_RES_TOKEN] = 1'b0;
         status_next[ST_RES_SIGNALLING_NAN_VALUE]  = 1'b0;
      end
      if (bad_op) begin
         status_next[ST_BAD_OP] = 1'b1;
      end
      status_next[ST_RSE_ACT] = rse_on && !leave;
   end

   // ------------------------------------------------------------------
   // Read decode
   // ------------------------------------------------------------------
   logic [31:0] rd_word;
   always_comb begin
      case (araddr)
         OFF_CTRL:    rd_word = ctrl_reg;
         OFF_STATUS:  rd_word = status_reg;
         OFF_CS_BASE: rd_word = cs_base_reg;
         OFF_EIP:     rd_word = eip_reg;
         OFF_OPCODE:  rd_word = opcode_reg;
         OFF_OPERAND: rd_word = operand_reg;
         OFF_TARGET:  rd_word = target_reg;
         OFF_LINK:    rd_word = link_reg;
         OFF_RESULT:  rd_word = result_reg;
         OFF_RSE:     rd_word = {{(32-CLEAN_W){1'b0}}, clean_reg};
         default:     rd_word = 32'h0000_0000;
      endcase
   end

   // ------------------------------------------------------------------
   // Bus channels
   // ------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= '0;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
      end else begin
         if (awvalid && awready_reg) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= awaddr;
            awready_reg <= 1'b0;
         end
         if (wvalid && wready_reg) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= wdata;
            wstrb_reg  <= wstrb;
            wready_reg <= 1'b0;
         end
         if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_reg && bready) begin
            bvalid_reg  <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         rresp_reg   <= RESP_OKAY;
      end else if (arvalid && arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rdata_reg   <= rd_word;
         rresp_reg   <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && rready) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Block registers
   // ------------------------------------------------------------------
   // No fence or drain is modelled: the jump retires in the write cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg    <= CTRL_RESET;
         status_reg  <= 32'h0000_0000;
         cs_base_reg <= 32'h0000_0000;
         eip_reg     <= 32'h0000_0000;
         opcode_reg  <= 32'h0000_0000;
         operand_reg <= 32'h0000_0000;
         target_reg  <= 32'h0000_0000;
         link_reg    <= 32'h0000_0000;
         result_reg  <= 32'h0000_0000;
         clean_reg   <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg) &
                        CTRL_STORE_MASK;
         end
         if (wr_cs_base) begin
            cs_base_reg <= merge(cs_base_reg, wdata_reg, wstrb_reg);
         end
         if (wr_opcode) begin
            opcode_reg <= merge(opcode_reg, wdata_reg, wstrb_reg);
         end
         if (wr_operand) begin
            operand_reg <= merge(operand_reg, wdata_reg, wstrb_reg);
         end
         status_reg <= status_next;
         eip_reg    <= eip_next;
         target_reg <= target_next;
         link_reg   <= link_next;
         result_reg <= result_next;
         clean_reg  <= clean_next;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign awready = awready_reg;
   assign wready  = wready_reg;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;
   assign arready = arready_reg;
   assign rvalid  = rvalid_reg;
   assign rdata   = rdata_reg;
   assign rresp   = rresp_reg;

endmodule
`default_nettype wire

//--- isa_switch_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module isa_switch_monitor
   import isa_switch_pkg::*;
(
   // Clock and reset
   input wire logic              aclk,
   input wire logic              aresetn,
   // Write channels
   input wire logic              awvalid,
   input wire logic              awready,
   input wire logic              wvalid,
   input wire logic              wready,
   input wire logic [1:0]        bresp,
   input wire logic              bvalid,
   input wire logic              bready,
   // Read channels
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic              arvalid,
   input wire logic              arready,
   input wire logic [31:0]       rdata,
   input wire logic [1:0]        rresp,
   input wire logic              rvalid,
   input wire logic              rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire logic ar_hs = arvalid && arready;
   wire logic bad_a = (araddr > OFF_RSE) || (araddr[1:0] != 2'h0);

   property p_b_answer;
      awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
   endproperty
   a_b_answer: assert property (p_b_answer)
      else $error("write response not two cycles after capture");
   property p_b_hold;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped before bready");
   property p_w_block;
      bvalid |-> !awready && !wready;
   endproperty
   a_w_block: assert property (p_w_block)
      else $error("write accepted while response pending");
   property p_r_answer;
      ar_hs |=> rvalid;
   endproperty
   a_r_answer: assert property (p_r_answer)
      else $error("read data not one cycle after address");
   property p_r_hold;
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data changed before rready");
   property p_ar_block;
      rvalid |-> !arready;
   endproperty
   a_ar_block: assert property (p_ar_block)
      else $error("read address accepted while data pending");
   property p_issue_zero;
      ar_hs && araddr == OFF_ISSUE |=> rdata == 32'h0000_0000;
   endproperty
   a_issue_zero: assert property (p_issue_zero)
      else $error("issue register read not zero");
   property p_unmapped;
      ar_hs && bad_a |=> rresp == RESP_SLVERR && rdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not refused");
   property p_rse_off;
      ar_hs && araddr == OFF_STATUS |=> !(rdata[ST_LEGACY] && rdata[ST_RSE_ACT]);
   endproperty
   a_rse_off: assert property (p_rse_off)
      else $error("stack engine active in legacy mode");
   property p_advanced_load_table_off;
      ar_hs && araddr == OFF_STATUS |=> !(rdata[ST_LEGACY] && rdata[ST_ADVANCED_LOAD_TABLE_VALID]);
   endproperty
   a_advanced_load_table_off: assert property (p_advanced_load_table_off)
      else $error("load table valid in legacy mode");
endmodule

bind legacy_to_native_isa_switch isa_switch_monitor isa_switch_monitor_inst (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
   .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
   .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import isa_switch_pkg::*;
   localparam int CMAX = 4;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          cycles = 0;

   legacy_to_native_isa_switch #(.CLEAN_W(8), .CLEAN_MAX(CMAX))
   legacy_to_native_isa_switch_inst (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));

   always #5 aclk = ~aclk;

   // -----------------------------------------------------------------
   // Bus tasks
   // -----------------------------------------------------------------
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = RESP_OKAY);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      cmp(32'(bresp), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      cmp(d & m, e);
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic s_reset();
      logic [31:0] d;
      logic [1:0]  r;
      chk(OFF_CTRL, 32'hffff_ffff, CTRL_RESET);
      chk(OFF_STATUS, 32'hffff_ffff, 32'h0);
      chk(OFF_ISSUE, 32'hffff_ffff, 32'h0);
      rd(8'h2c, d, r);
      cmp(32'(r), 32'(RESP_SLVERR));
      rd(8'h02, d, r);
      cmp(32'(r), 32'(RESP_SLVERR));
      wr(8'h2c, 32'h1, RESP_SLVERR);
   endtask
   task automatic s_enter();
      wr(OFF_CTRL, 32'h0000_0122);
      chk(OFF_STATUS, 32'h0000_0807, 32'h0000_0806);
      chk(OFF_RSE, 32'h0000_00ff, CMAX);
      wr(OFF_CTRL, 32'h0000_0023);
      chk(OFF_STATUS, 32'h0000_0007, 32'h0000_0001);
      chk(OFF_RSE, 32'h0000_00ff, CMAX);
   endtask
   task automatic s_jump_abs();
      wr(OFF_CTRL, 32'h0000_0060);
      wr(OFF_CS_BASE, 32'h0000_1000);
      wr(OFF_EIP, 32'h0000_0200);
      wr(OFF_OPCODE, 32'h0040_b80f);
      wr(OFF_OPERAND, 32'h1234_5678);
      chk(OFF_STATUS, 32'h0000_0009, 32'h0000_0009);
      wr(OFF_ISSUE, 32'h0);
      chk(OFF_TARGET, 32'hffff_ffff, 32'h1234_6670);
      chk(OFF_EIP, 32'hffff_ffff, 32'h1234_6670);
      chk(OFF_LINK, 32'hffff_ffff, 32'h0000_0204);
      chk(OFF_STATUS, 32'h0000_0889, 32'h0000_0080);
      chk(OFF_RSE, 32'h0000_00ff, 32'h0);
   endtask
   task automatic s_jump_ind16();
      wr(OFF_CTRL, 32'h0000_0001);
      wr(OFF_EIP, 32'h0000_fffe);
      wr(OFF_OPCODE, 32'h0036_000f);
      wr(OFF_OPERAND, 32'habcd_8001);
      wr(OFF_ISSUE, 32'h0);
      chk(OFF_TARGET, 32'hffff_ffff, 32'h0000_9001);
      chk(OFF_LINK, 32'hffff_ffff, 32'h0000_0001);
   endtask
   task automatic s_wait_bad();
      wr(OFF_CTRL, 32'h0000_0021);
      wr(OFF_STATUS, STICKY_MASK);
      wr(OFF_ISSUE, 32'h0000_0010);
      chk(OFF_STATUS, 32'h0000_00c1, 32'h0000_0041);
      wr(OFF_OPCODE, 32'h0036_010f);
      wr(OFF_ISSUE, 32'h0);
      chk(OFF_STATUS, 32'h0000_0181, 32'h0000_0101);
   endtask
   task automatic s_int();
      wr(OFF_CTRL, 32'h0000_0024);
      wr(OFF_EIP, 32'h0000_0100);
      wr(OFF_OPCODE, 32'h0020_0000);
      wr(OFF_OPERAND, 32'h5555_aaaa);
      wr(OFF_STATUS, STICKY_MASK);
      wr(OFF_ISSUE, 32'h0000_0005);
      chk(OFF_STATUS, 32'h0000_0010, 32'h0000_0010);
      chk(OFF_EIP, 32'hffff_ffff, 32'h0000_0102);
      wr(OFF_CTRL, 32'h0000_0020);
      wr(OFF_ISSUE, 32'h0000_0005);
      chk(OFF_RESULT, 32'hffff_ffff, 32'h5555_aaaa);
      chk(OFF_STATUS, 32'h0000_0200, 32'h0000_0200);
   endtask
   task automatic s_fp();
      wr(OFF_CTRL, 32'h0000_0028);
      wr(OFF_STATUS, STICKY_MASK);
      wr(OFF_ISSUE, 32'h0000_000a);
      chk(OFF_STATUS, 32'h0000_0020, 32'h0000_0020);
      wr(OFF_ISSUE, 32'h0000_0002);
      chk(OFF_STATUS, 32'h0000_0620, 32'h0000_0020);
      wr(OFF_CTRL, 32'h0000_0020);
      wr(OFF_ISSUE, 32'h0000_000a);
      chk(OFF_RESULT, 32'hffff_ffff, SIGNALLING_NAN_VALUE_VALUE);
      chk(OFF_STATUS, 32'h0000_0600, 32'h0000_0600);
      wr(OFF_ISSUE, 32'h0000_000b);
      chk(OFF_RESULT, 32'hffff_ffff, 32'h5555_aaaa);
      chk(OFF_STATUS, 32'h0000_0600, 32'h0);
   endtask
   task automatic s_exit();
      wr(OFF_CTRL, 32'h0000_00b0);
      chk(OFF_STATUS, 32'h0000_0801, 32'h0);
      wr(OFF_CTRL, 32'h0000_0031);
      chk(OFF_STATUS, 32'h0000_1001, 32'h0000_1001);
      wr(OFF_ISSUE, 32'h0000_000a);
      chk(OFF_STATUS, 32'h0000_0600, 32'h0000_0400);
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // The whole run needs a few hundred cycles; the ceiling is generous.
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      s_reset();
      s_enter();
      s_jump_abs();
      s_jump_ind16();
      s_wait_bad();
      s_int();
      s_fp();
      s_exit();
      report_and_stop();
   end
endmodule
`default_nettype wire
